// >>> logic/dsm_pkg.sv
package dsm_pkg;
	// register offsets (word index on the plain register port)
	localparam logic [1:0] DSM_OFS_CONTROL = 2'h0;
	localparam logic [1:0] DSM_OFS_SOURCE = 2'h1;
	localparam logic [1:0] DSM_OFS_CARRIER = 2'h2;
	// control register field positions
	localparam int DSM_CTL_ENABLE_POS = 15;
	localparam int DSM_CTL_IDLE_STOP_POS = 13;
	localparam int DSM_CTL_PIN_OE_POS = 6;
	localparam int DSM_CTL_SLEW_POS = 5;
	localparam int DSM_CTL_OUT_POL_POS = 4;
	localparam int DSM_CTL_MANUAL_POS = 0;
	// source register field positions
	localparam int DSM_SRC_DISABLE_POS = 7;
	localparam int DSM_SRC_SEL_LSB = 0;
	// carrier register field positions
	localparam int DSM_CAR_HI_DIS_POS = 15;
	localparam int DSM_CAR_HI_POL_POS = 14;
	localparam int DSM_CAR_HI_SYNC_POS = 13;
	localparam int DSM_CAR_HI_SEL_LSB = 8;
	localparam int DSM_CAR_LO_DIS_POS = 7;
	localparam int DSM_CAR_LO_POL_POS = 6;
	localparam int DSM_CAR_LO_SYNC_POS = 5;
	localparam int DSM_CAR_LO_SEL_LSB = 0;
	// implemented-bit masks
	localparam logic [15:0] DSM_CONTROL_MASK = 16'ha071;
	localparam logic [15:0] DSM_SOURCE_MASK = 16'h008f;
	localparam logic [15:0] DSM_CARRIER_MASK = 16'hefef;
	// reset values
	localparam logic [15:0] DSM_CONTROL_RST = 16'h0000;
	localparam logic [15:0] DSM_CARRIER_RST = 16'h0000;
	localparam logic DSM_SRC_DISABLE_RST = 1'h0;
	// source and carrier codes
	localparam logic [3:0] DSM_SRC_MANUAL = 4'h0;
	localparam logic [3:0] DSM_SRC_PIN = 4'h1;
	localparam logic [3:0] DSM_SRC_SPI_LO = 4'h2;
	localparam logic [3:0] DSM_SRC_UART_LO = 4'h4;
	localparam logic [3:0] DSM_SRC_CMP_LO = 4'h8;
	localparam logic [3:0] DSM_SRC_CMP_HI = 4'he;
	localparam logic [3:0] DSM_CAR_GROUND = 4'h0;
	localparam logic [3:0] DSM_CAR_PIN_ONE = 4'h1;
	localparam logic [3:0] DSM_CAR_PIN_TWO = 4'h2;
	localparam logic [3:0] DSM_CAR_REF = 4'h3;
	localparam logic [3:0] DSM_CAR_CMP_LO = 4'h4;
	localparam logic [3:0] DSM_CAR_CMP_HI = 4'ha;
	// carrier-path selection state
	typedef enum logic {DSM_USE_LOW, DSM_USE_HIGH} dsm_path_t;
	// one carrier's settings
	typedef struct packed {
		logic disable_out;
		logic polarity;
		logic sync;
		logic [3:0] sel;
	} dsm_carrier_cfg_t;
	// peripheral signal bundle feeding the modulator
	typedef struct packed {
		logic [6:0] cmp_pwm;
		logic [3:0] uart_tx;
		logic [1:0] serial_data_out;
		logic reference_output;
		logic carrier_input_pin_two;
		logic carrier_input_pin_one;
		logic modulation_input_pin;
	} dsm_sources_t;
endpackage

// >>> logic/dsm_signal_modulator.sv
`timescale 1ns/1ns
// Overview of operation
// - output is high carrier while modulator high, else low carrier
// - enable bit mixes, else no output
// - idle-stop halts modulation during idle
// - pin enable gates output pin drive
// - output polarity bit inverts final output
// - manual bit modulates when source is 0000
// - source field picks modulating signal
// - source disable blocks source's own pin
// - source disable reset by power-on only
// - source select survives power-on reset
// - high carrier select decodes carrier sources
// - low carrier select decodes identically
// - high disable blocks high carrier's pin
// - low disable blocks low carrier's pin
// - high polarity inverts high carrier
// - low polarity inverts low carrier
// - high sync waits high falling edge
// - low sync waits low falling edge
// - unsynced switch may happen anytime
// - unimplemented bits ignore writes, read zero
module dsm_signal_modulator
	import dsm_pkg::*;
#(
	parameter int ADDR_W = 2
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic por_resetn_in,
	input wire logic idle_mode_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [15:0] reg_rdata_out,
	input wire dsm_sources_t sources_in,
	output logic modulated_output_pin_out,
	output logic modulated_output_pin_oe_out,
	output logic pin_slew_limit_out,
	output logic [15:0] periph_pin_block_out
);

	// source-select decode, used for the modulator only; carriers use pick_carrier
	function automatic logic pick_source(input logic [3:0] code, input dsm_sources_t s,
		input logic manual);
		logic v;
		// unimplemented code falls through to low
		v = 1'b0;
		if (code == DSM_SRC_MANUAL) begin
			// software bit as modulator
			v = manual;
		end else if (code == DSM_SRC_PIN) begin
			// modulation input pin
			v = s.modulation_input_pin;
		end else if (code < DSM_SRC_UART_LO) begin
			// two serial data outputs, low code bit picks
			v = s.serial_data_out[code[0]];
		end else if (code < DSM_SRC_CMP_LO) begin
			// four uart transmit outputs
			v = s.uart_tx[code[1:0]];
		end else if (code <= DSM_SRC_CMP_HI) begin
			// seven compare/pwm outputs
			v = s.cmp_pwm[3'(code - DSM_SRC_CMP_LO)];
		end
		return v;
	endfunction

	// carrier decode, shared by both carriers
	function automatic logic pick_carrier(input logic [3:0] code, input dsm_sources_t s);
		logic v;
		// ground and reserved codes give low
		v = 1'b0;
		if (code == DSM_CAR_PIN_ONE) begin
			// first carrier input pin
			v = s.carrier_input_pin_one;
		end else if (code == DSM_CAR_PIN_TWO) begin
			// second carrier input pin
			v = s.carrier_input_pin_two;
		end else if (code == DSM_CAR_REF) begin
			// reference clock output
			v = s.reference_output;
		end else if (code >= DSM_CAR_CMP_LO && code <= DSM_CAR_CMP_HI) begin
			// compare/pwm outputs one to seven
			v = s.cmp_pwm[3'(code - DSM_CAR_CMP_LO)];
		end
		return v;
	endfunction

	// pin-block bit position of a carrier code, one-hot over the 16-bit block map
	function automatic logic [15:0] carrier_block(input logic [3:0] code);
		logic [15:0] m;
		// ground and reserved codes block nothing
		m = 16'h0000;
		if (code == DSM_CAR_PIN_ONE) begin
			// carrier pin one
			m[11] = 1'b1;
		end else if (code == DSM_CAR_PIN_TWO) begin
			// carrier pin two
			m[12] = 1'b1;
		end else if (code == DSM_CAR_REF) begin
			// reference output
			m[13] = 1'b1;
		end else if (code >= DSM_CAR_CMP_LO && code <= DSM_CAR_CMP_HI) begin
			// compare/pwm pins, shared with source map
			m[4'(code - DSM_CAR_CMP_LO) + 4'h4] = 1'b1;
		end
		return m;
	endfunction

	// pin-block bit position of a modulation source code
	function automatic logic [15:0] source_block(input logic [3:0] code);
		logic [15:0] m;
		// manual and unimplemented codes block nothing
		m = 16'h0000;
		if (code == DSM_SRC_PIN) begin
			// modulation input pin
			m[14] = 1'b1;
		end else if (code >= DSM_SRC_SPI_LO && code < DSM_SRC_CMP_LO) begin
			// serial data and uart outputs
			m[4'(code - DSM_SRC_SPI_LO) + 4'h0] = 1'b1;
		end else if (code >= DSM_SRC_CMP_LO && code <= DSM_SRC_CMP_HI) begin
			// compare/pwm outputs
			m[4'(code - DSM_SRC_CMP_LO) + 4'h4] = 1'b1;
		end
		// top bit is never used
		m[15] = 1'b0;
		return m;
	endfunction

	// first synchroniser stage, read only by the second
	dsm_sources_t sync1_ff;
	// second stage, the only copy logic may read
	dsm_sources_t sync2_ff;
	logic idle1_ff; // idle level, first stage
	logic idle2_ff; // idle level, synchronised

	// registers
	logic [15:0] control_ff; // control, implemented bits only
	logic [15:0] nxt_control;
	logic source_disable_ff; // survives system reset
	logic nxt_source_disable;
	logic [3:0] source_sel_ff; // no reset at all
	logic [3:0] nxt_source_sel;
	logic [15:0] carrier_ff; // both carrier settings
	logic [15:0] nxt_carrier;
	logic [15:0] rdata_ff; // read data, one cycle only
	logic [15:0] nxt_rdata;

	// modulation path state
	dsm_path_t path_ff; // carrier currently passed
	dsm_path_t nxt_path;
	logic hi_prev_ff; // high carrier last cycle, for fall detect
	logic lo_prev_ff; // low carrier last cycle, for fall detect
	logic pin_ff; // output pin level
	logic nxt_pin;
	logic pin_oe_ff; // output pin drive enable
	logic nxt_pin_oe;
	logic slew_ff; // slew limit request to the pad
	logic nxt_slew;
	logic [15:0] block_ff; // peripheral pins held off
	logic [15:0] nxt_block;

	// derived values
	dsm_carrier_cfg_t hi_cfg; // high carrier settings
	dsm_carrier_cfg_t lo_cfg; // low carrier settings
	logic mod_level; // selected modulating level
	logic hi_car; // high carrier after polarity
	logic lo_car; // low carrier after polarity
	logic running; // enabled and not stopped by idle
	logic nxt_mod_out; // internal output before polarity

	// two-flop input synchroniser
	// pins and peripherals may run off other clocks; only stage two is read
	always_ff @(posedge core_clk_in) begin
		// source bundle
		sync1_ff <= sources_in;
		sync2_ff <= sync1_ff;
		// idle level
		idle1_ff <= idle_mode_in;
		idle2_ff <= idle1_ff;
	end

	// unpack carrier register fields
	always_comb begin
		// high carrier from the upper byte
		hi_cfg = '{carrier_ff[DSM_CAR_HI_DIS_POS], carrier_ff[DSM_CAR_HI_POL_POS],
			carrier_ff[DSM_CAR_HI_SYNC_POS], carrier_ff[DSM_CAR_HI_SEL_LSB +: 4]};
		// low carrier from the lower byte
		lo_cfg = '{carrier_ff[DSM_CAR_LO_DIS_POS], carrier_ff[DSM_CAR_LO_POL_POS],
			carrier_ff[DSM_CAR_LO_SYNC_POS], carrier_ff[DSM_CAR_LO_SEL_LSB +: 4]};
	end

	// register write and read decode
	always_comb begin
		nxt_control = control_ff;
		nxt_source_disable = source_disable_ff;
		nxt_source_sel = source_sel_ff;
		nxt_carrier = carrier_ff;
		nxt_rdata = 16'h0000;
		if (reg_write_in) begin
			// unimplemented bits are masked away
			unique case (reg_addr_in)
				// control keeps its implemented bits
				DSM_OFS_CONTROL: nxt_control = reg_wdata_in & DSM_CONTROL_MASK;
				// source keeps only its two fields
				DSM_OFS_SOURCE: begin
					nxt_source_disable = reg_wdata_in[DSM_SRC_DISABLE_POS];
					nxt_source_sel = reg_wdata_in[DSM_SRC_SEL_LSB +: 4];
				end
				// carrier keeps its implemented bits
				DSM_OFS_CARRIER: nxt_carrier = reg_wdata_in & DSM_CARRIER_MASK;
				default: ;
			endcase
		end
		if (reg_read_in) begin
			// unmapped addresses read zero
			unique case (reg_addr_in)
				// stored bits are already masked
				DSM_OFS_CONTROL: nxt_rdata = control_ff;
				DSM_OFS_SOURCE: begin
					// other source bits read zero
					nxt_rdata[DSM_SRC_DISABLE_POS] = source_disable_ff;
					nxt_rdata[DSM_SRC_SEL_LSB +: 4] = source_sel_ff;
				end
				// carrier read as stored
				DSM_OFS_CARRIER: nxt_rdata = carrier_ff;
				default: ;
			endcase
		end
	end

	// register storage; system reset and power-on reset act differently
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in || !por_resetn_in) begin
			// either reset clears the control side
			control_ff <= DSM_CONTROL_RST;
			carrier_ff <= DSM_CARRIER_RST;
			rdata_ff <= 16'h0000;
		end else begin
			// normal register update
			control_ff <= nxt_control;
			carrier_ff <= nxt_carrier;
			rdata_ff <= nxt_rdata;
		end
		// only power-on reset touches the source disable bit
		if (!por_resetn_in) begin
			source_disable_ff <= DSM_SRC_DISABLE_RST;
		end else if (resetn_in) begin
			source_disable_ff <= nxt_source_disable;
		end
		// source select has no reset at all
		if (resetn_in && por_resetn_in) begin
			source_sel_ff <= nxt_source_sel;
		end
	end

	// mixing path: carrier choice and modulated level
	always_comb begin
		// idle stop only matters while enabled
		running = control_ff[DSM_CTL_ENABLE_POS] &&
			!(control_ff[DSM_CTL_IDLE_STOP_POS] && idle2_ff);
		// modulating level from the synchronised sources
		mod_level = pick_source(source_sel_ff, sync2_ff, control_ff[DSM_CTL_MANUAL_POS]);
		// both carriers after their own polarity
		hi_car = pick_carrier(hi_cfg.sel, sync2_ff) ^ hi_cfg.polarity;
		lo_car = pick_carrier(lo_cfg.sel, sync2_ff) ^ lo_cfg.polarity;
		// hold the path unless a switch is allowed
		nxt_path = path_ff;
		if (mod_level && path_ff == DSM_USE_LOW) begin
			// switch to high; with low sync wait for low carrier fall
			if (!lo_cfg.sync || (lo_prev_ff && !lo_car)) begin
				nxt_path = DSM_USE_HIGH;
			end
		end else if (!mod_level && path_ff == DSM_USE_HIGH) begin
			// switch to low; with high sync wait for high carrier fall
			if (!hi_cfg.sync || (hi_prev_ff && !hi_car)) begin
				nxt_path = DSM_USE_LOW;
			end
		end
		// carrier picked by modulator: high carrier while one, low carrier while zero
		nxt_mod_out = 1'b0;
		if (running) begin
			// path already switched this cycle, so no extra lag
			nxt_mod_out = (nxt_path == DSM_USE_HIGH) ? hi_car : lo_car;
		end
		// disabled holds low before polarity
		nxt_pin = nxt_mod_out ^ control_ff[DSM_CTL_OUT_POL_POS];
	end

	// pad controls and peripheral pin blocking
	always_comb begin
		// pad controls follow the control register
		nxt_pin_oe = control_ff[DSM_CTL_PIN_OE_POS];
		nxt_slew = control_ff[DSM_CTL_SLEW_POS];
		// peripheral pins blocked by the disable bits
		nxt_block = 16'h0000;
		// source's own pin
		if (source_disable_ff) begin
			nxt_block = nxt_block | source_block(source_sel_ff);
		end
		// high carrier's own pin
		if (hi_cfg.disable_out) begin
			nxt_block = nxt_block | carrier_block(hi_cfg.sel);
		end
		// low carrier's own pin
		if (lo_cfg.disable_out) begin
			nxt_block = nxt_block | carrier_block(lo_cfg.sel);
		end
	end

	// mixing path registers
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in || !por_resetn_in) begin
			// both resets park on the low carrier, outputs low
			path_ff <= DSM_USE_LOW;
			hi_prev_ff <= 1'b0;
			lo_prev_ff <= 1'b0;
			pin_ff <= 1'b0;
			pin_oe_ff <= 1'b0;
			slew_ff <= 1'b0;
			block_ff <= 16'h0000;
		end else begin
			// prev copies feed the falling-edge detect
			path_ff <= nxt_path;
			hi_prev_ff <= hi_car;
			lo_prev_ff <= lo_car;
			pin_ff <= nxt_pin;
			pin_oe_ff <= nxt_pin_oe;
			slew_ff <= nxt_slew;
			block_ff <= nxt_block;
		end
	end

	// outputs straight from flops
	assign reg_rdata_out = rdata_ff;
	assign modulated_output_pin_out = pin_ff;
	assign modulated_output_pin_oe_out = pin_oe_ff;
	assign pin_slew_limit_out = slew_ff;
	assign periph_pin_block_out = block_ff;

endmodule

// >>> dv/dsm_src_model.sv
`timescale 1ns/1ns
// stands in for the pins and peripherals feeding the modulator
module dsm_src_model
	import dsm_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic run_in,
	input wire logic mod_level_in,
	output dsm_sources_t sources_out
);
	logic [2:0] cnt_ff = 3'h0; // carrier phase
	logic [2:0] nxt_cnt;
	// phase advances only while carriers run
	always_comb begin
		nxt_cnt = run_in ? cnt_ff + 3'h1 : cnt_ff;
	end
	always_ff @(posedge core_clk_in) begin
		cnt_ff <= nxt_cnt;
	end
	// odd codes carry the level, even codes its inverse
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			sources_out.cmp_pwm[i] = mod_level_in ^ (i % 2 == 0);
		end
		for (int i = 0; i < 4; i++) begin
			sources_out.uart_tx[i] = mod_level_in ^ (i % 2 == 0);
		end
		sources_out.serial_data_out = {mod_level_in, !mod_level_in};
		sources_out.modulation_input_pin = mod_level_in;
		// stopped carriers rest at fixed levels
		sources_out.carrier_input_pin_one = run_in ? cnt_ff[1] : 1'h1;
		sources_out.carrier_input_pin_two = run_in ? cnt_ff[2] : 1'h0;
		sources_out.reference_output = run_in ? cnt_ff[0] : 1'h1;
	end
endmodule

// >>> dv/dsm_signal_modulator_chk.sv
`timescale 1ns/1ns
// watches register port and pin outputs
module dsm_signal_modulator_chk #(
	parameter int ADDR_W = 2
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic por_resetn_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic modulated_output_pin_out,
	input wire logic modulated_output_pin_oe_out,
	input wire logic [15:0] periph_pin_block_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in || !por_resetn_in);
	// implemented bits per register
	function automatic logic [15:0] msk(input logic [1:0] a);
		return a == 0 ? 16'ha071 : a == 1 ? 16'h008f : a == 2 ? 16'hefef : 16'h0000;
	endfunction
	// a write, then a quiet cycle
	sequence s_wr(int a);
		reg_write_in && reg_addr_in == a ##1 !reg_write_in;
	endsequence
	property p_rd_unmapped;
		reg_read_in && reg_addr_in == 3 |=> reg_rdata_out == 16'h0000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
	property p_rd_mask;
		reg_read_in |=> (reg_rdata_out & ~msk($past(reg_addr_in))) == 16'h0000;
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("unused bit read");
	property p_readback;
		s_wr(0) ##1 reg_read_in && reg_addr_in == 0
			|=> reg_rdata_out == ($past(reg_wdata_in, 3) & 16'ha071);
	endproperty
	a_readback: assert property (p_readback) else $error("control readback");
	property p_pin_oe;
		s_wr(0) |-> ##1 modulated_output_pin_oe_out == $past(reg_wdata_in[6], 2);
	endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("pin enable");
	property p_off_level;
		s_wr(0) ##0 $past(!reg_wdata_in[15])
			|-> ##1 modulated_output_pin_out == $past(reg_wdata_in[4], 2);
	endproperty
	a_off_level: assert property (p_off_level) else $error("disabled level");
	property p_src_block;
		s_wr(1) ##0 $past(reg_wdata_in[7] && reg_wdata_in[3:0] == 2) |-> ##1 periph_pin_block_out[0];
	endproperty
	a_src_block: assert property (p_src_block) else $error("source pin");
	property p_hi_block;
		s_wr(2) ##0 $past(reg_wdata_in[15] && reg_wdata_in[11:8] == 1) |-> ##1 periph_pin_block_out[11];
	endproperty
	a_hi_block: assert property (p_hi_block) else $error("high pin");
	property p_lo_block;
		s_wr(2) ##0 $past(reg_wdata_in[7] && reg_wdata_in[3:0] == 3) |-> ##1 periph_pin_block_out[13];
	endproperty
	a_lo_block: assert property (p_lo_block) else $error("low pin");
endmodule
bind dsm_signal_modulator dsm_signal_modulator_chk #(.ADDR_W(ADDR_W)) u_chk (
	.core_clk_in(core_clk_in), .resetn_in(resetn_in), .por_resetn_in(por_resetn_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
	.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
	.modulated_output_pin_out(modulated_output_pin_out),
	.modulated_output_pin_oe_out(modulated_output_pin_oe_out),
	.periph_pin_block_out(periph_pin_block_out));

// >>> dv/tb_data_signal_modulator.sv
`timescale 1ns/1ns
// self-checking bench for the modulator
module tb_data_signal_modulator;
	import dsm_pkg::*;
	// row: control, source, carrier, level, pin
	typedef struct packed {logic [15:0] c, s, k; logic m, e;} dsm_row_t;
	logic core_clk_in = 1'h0, resetn_in = 1'h0, por_resetn_in = 1'h0, idle = 1'h0;
	logic reg_write_in = 1'h0, reg_read_in = 1'h0, run = 1'h0, mlev = 1'h0, pin, oe, slew;
	logic [1:0] reg_addr_in = 2'h0;
	logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, blk;
	dsm_sources_t src;
	int n_fail = 0, checks_done = 0, cyc = 0;
	logic [15:0] msk [4] = '{16'ha071, 16'h008f, 16'hefef, 16'h0000};
	dsm_row_t rows [8] = '{'{16'h8061, 16'h0, 16'h0100, 1'h0, 1'h1},
		'{16'h8000, 16'h0, 16'h0100, 1'h0, 1'h0}, '{16'h8010, 16'h0, 16'h0100, 1'h0, 1'h1},
		'{16'h0011, 16'h0, 16'h0100, 1'h0, 1'h1}, '{16'h0001, 16'h0, 16'h0100, 1'h0, 1'h0},
		'{16'h8000, 16'h2, 16'h0042, 1'h1, 1'h1}, '{16'h8001, 16'h0, 16'h4000, 1'h0, 1'h1},
		'{16'h8000, 16'hf, 16'h0040, 1'h1, 1'h1}};
	dsm_signal_modulator #(.ADDR_W(2)) u_dsm_signal_modulator (.core_clk_in(core_clk_in),
		.resetn_in(resetn_in), .por_resetn_in(por_resetn_in), .idle_mode_in(idle),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
		.reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .sources_in(src),
		.modulated_output_pin_out(pin), .modulated_output_pin_oe_out(oe),
		.pin_slew_limit_out(slew), .periph_pin_block_out(blk));
	dsm_src_model u_dsm_src_model (.core_clk_in(core_clk_in), .run_in(run),
		.mod_level_in(mlev), .sources_out(src));
	initial forever #10 core_clk_in = ~core_clk_in;
	// hang guard
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		reg_write_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_write_in <= 1'h0;
	endtask
	// read, data sampled the cycle after
	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		@(posedge core_clk_in);
		reg_read_in <= 1'h1;
		reg_addr_in <= a;
		@(posedge core_clk_in);
		reg_read_in <= 1'h0;
		#1 cmp(reg_rdata_out, e);
	endtask
	// program all three registers, then look at the pin
	task automatic apply(input dsm_row_t r);
		wr(2'h0, r.c);
		wr(2'h1, r.s);
		wr(2'h2, r.k);
		mlev <= r.m;
		repeat (5) @(posedge core_clk_in);
		#1 cmp(pin, r.e);
		cmp(oe, r.c[6]);
		cmp(slew, r.c[5]);
	endtask
	// static carrier level per code, level low
	function automatic logic hv(input int c);
		return c == 1 || c == 3 || (c >= 4 && c <= 10 && c % 2 == 0);
	endfunction
	initial begin
		repeat (16) @(posedge core_clk_in);
		resetn_in <= 1'h1;
		por_resetn_in <= 1'h1;
		rd(2'h0, 16'h0000);
		rd(2'h2, 16'h0000);
		foreach (rows[i]) apply(rows[i]);
		for (int c = 1; c < 16; c++) begin
			apply('{16'h8000, 16'(c), 16'h0100, c[1], c != 15 && (c[1] ^ !c[0])});
		end
		for (int j = 0; j < 2; j++) begin
			for (int c = 0; c < 16; c++) begin
				apply('{16'h8000 | 16'(j), 16'h0, 16'(c << (8 * j)), 1'h0, hv(c)});
			end
		end
		for (int a = 0; a < 4; a++) begin
			wr(2'(a), 16'hffff);
			rd(2'(a), msk[a]);
		end
		idle <= 1'h1;
		apply('{16'ha001, 16'h0, 16'h0100, 1'h0, 1'h0});
		apply('{16'h8001, 16'h0, 16'h0100, 1'h0, 1'h1});
		idle <= 1'h0;
		for (int j = 0; j < 2; j++) begin
			apply('{16'h8000 | 16'(j), 16'h0, j ? 16'h2100 : 16'h0021, 1'h0, 1'h1});
			wr(2'h0, 16'h8000 | 16'(!j));
			repeat (6) @(posedge core_clk_in);
			#1 cmp(pin, 16'h1);
			@(posedge core_clk_in);
			run <= 1'h1;
			repeat (12) @(posedge core_clk_in);
			run <= 1'h0;
			repeat (4) @(posedge core_clk_in);
			#1 cmp(pin, 16'h0);
		end
		wr(2'h1, 16'h0082);
		wr(2'h2, 16'h8183);
		repeat (3) @(posedge core_clk_in);
		#1 cmp(blk & 16'h2801, 16'h2801);
		@(posedge core_clk_in);
		resetn_in <= 1'h0;
		@(posedge core_clk_in);
		resetn_in <= 1'h1;
		rd(2'h1, 16'h0082);
		rd(2'h2, 16'h0000);
		@(posedge core_clk_in);
		por_resetn_in <= 1'h0;
		@(posedge core_clk_in);
		por_resetn_in <= 1'h1;
		rd(2'h1, 16'h0002);
		print_verdict();
	end
endmodule
